// ===== shared/mbhi_pkg.sv
// Purpose: Shared constants, types and decode helpers for the multiplexed bus host port.
// Assumes: Strobes and bus pins arrive already synchronous to clk.
// Notes: Command codes and reset values are plain defaults; change them here only.
package mbhi_pkg;

	// Recovery and reset stretch, in clk cycles
	localparam int RECOVERY_CYC = 4;
	localparam int RESET_STRETCH_CYC = 4;

	// Register numbers seen by this port
	localparam logic [3:0] IDX_COMMAND = 4'h0;
	localparam logic [3:0] IDX_VECTOR = 4'h2;
	localparam logic [3:0] IDX_BUFFER = 4'h8;
	localparam logic [3:0] IDX_MASTER = 4'h9;

	// Channel select bit positions and channel codes
	localparam int AD_CHAN_LEFT = 5;
	localparam int AD_CHAN_RIGHT = 0;
	localparam logic CHAN_B = 1'b0;

	// Shift select command in the channel B command register
	localparam int SHIFT_CMD_LSB = 0;
	localparam logic [1:0] CMD_SHIFT_LEFT = 2'h2;
	localparam logic [1:0] CMD_SHIFT_RIGHT = 2'h3;

	// Reset command field of the master control register
	localparam int MCR_CMD_LSB = 6;
	localparam int MCR_KEEP_W = 6;
	localparam logic [1:0] RST_CHAN_B = 2'h1;
	localparam logic [1:0] RST_CHAN_A = 2'h2;
	localparam logic [1:0] RST_FULL = 2'h3;

	// Reset values
	localparam logic [MCR_KEEP_W-1:0] MCR_RESET_VAL = 6'h00;
	localparam logic [7:0] VECTOR_RESET_VAL = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b100
	} mbhi_state_e;

	// One register request toward the channels
	typedef struct packed {
		logic chan;
		logic [3:0] index;
		logic [7:0] data;
	} mbhi_xfer_s;

	// Channel bit depends on the shift mode
	function automatic logic decode_chan(input logic [7:0] addr, input logic shift_right);
		decode_chan = shift_right ? addr[AD_CHAN_RIGHT] : addr[AD_CHAN_LEFT];
	endfunction : decode_chan

	// Register number sits on bits 4 to 1 in both modes
	function automatic logic [3:0] decode_index(input logic [7:0] addr);
		decode_index = addr[4:1];
	endfunction : decode_index

	// Incomplete read decode: unused numbers fold onto real read registers
	function automatic logic [3:0] read_alias(input logic [3:0] idx);
		case (idx)
			4'h4, 4'h5, 4'h6, 4'h7: read_alias = {2'b00, idx[1:0]};
			4'h9: read_alias = 4'hD;
			4'hB: read_alias = 4'hF;
			4'hE: read_alias = 4'hA;
			default: read_alias = idx;
		endcase
	endfunction : read_alias

endpackage : mbhi_pkg

// ===== hdl/mbhi_hold.sv
// Purpose: Cycle hold counter used for reset stretching and access recovery.
// Assumes: One clock; hold_in and start are synchronous.
// Notes: busy covers the hold level plus CYCLES cycles after it ends.
`timescale 1ns/1ps
module mbhi_hold #(
	parameter int unsigned CYCLES = 4
) (
	input wire logic clk,
	input wire logic clr,
	input wire logic hold_in,
	input wire logic start,
	output logic busy
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] cnt_q;

	// Load wins over clear so a held reset always restarts the count
	always_ff @(posedge clk) begin
		if (hold_in || start) begin
			cnt_q <= LOAD;
		end else if (clr) begin
			cnt_q <= '0;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign busy = hold_in || (cnt_q != '0);

endmodule : mbhi_hold

// ===== hdl/mbhi_port.sv
// Purpose: Device end of a multiplexed address/data host port for a two-channel serial controller.
// Assumes: All pins sampled on clk; muxed bus split into in, out and enable.
// Notes: Channel registers live outside; this block decodes, times and answers.
// Summary of operation
// R1 - Address strobe rising edge captures address, acknowledge flag and latched select.
// R2 - Host keeps address strobe cycling; each rising edge pulses a pending update.
// R3 - Four clock recovery after data strobe falls; accesses inside it are ignored.
// R4 - Buffer register accesses count recovery from data strobe rising instead.
// R5 - Host holds direction high before data strobe falls for a read.
// R6 - Read data driven only while live select high and data strobe low.
// R7 - Host holds direction low when data strobe falls for a write.
// R8 - Write data and direction captured at first live select with data strobe low.
// R9 - Acknowledge cycle ignores address, both selects and direction throughout.
// R10 - Host lets priority chains settle before data strobe falls in acknowledge.
// R11 - Answered acknowledge sets under-service and drives the vector onto the bus.
// R12 - Answered acknowledge deasserts the interrupt output at data strobe fall.
// R13 - Host gives one data strobe per acknowledge cycle.
// R14 - Hardware reset selects shift-left decode: channel on bit 5.
// R15 - Shift-right decode takes channel from bit 0, register from bits 4 to 1.
// R16 - Shift mode set by command code in channel B command register.
// R17 - Read numbers decoded incompletely; unused numbers alias existing read registers.
// R18 - One vector register and one master control register, writable from either channel.
// R19 - Both strobes low together is hardware reset, held while it lasts.
// R20 - Internal reset stretched four more cycles; accesses ignored meanwhile.
// R21 - Two-bit master field gives channel A, channel B and full resets.
// R22 - Other master bits written with a reset command are kept.
// R23 - Bus drivers released outside reads and answered acknowledges.
`timescale 1ns/1ps
module mbhi_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic select_latched_n,
	input wire logic select_live,
	input wire logic ack_cycle_n,
	input wire logic direction,
	input wire logic chain_enable_in,
	input wire logic [7:0] muxed_bus_in,
	output logic [7:0] muxed_bus_out,
	output logic muxed_bus_oe,
	output logic irq_out_n,
	input wire logic int_request,
	input wire logic [7:0] int_vector,
	output logic ius_set,
	output logic pending_update,
	output mbhi_pkg::mbhi_xfer_s reg_req,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] rd_data,
	output logic shift_right,
	output logic [7:0] vector_reg,
	output logic [5:0] master_control,
	output logic chan_a_reset,
	output logic chan_b_reset,
	output logic dev_reset
);
	import mbhi_pkg::*;

	mbhi_state_e state_q;
	logic as_q, ds_q, coinc_q;
	logic [7:0] addr_q;
	logic ack_q, sel_q, buf_q, drv_q, answered_q;
	logic [7:0] bus_out_q;
	logic oe_q, irq_n_q, ius_q, pend_q, rd_load_q;
	mbhi_xfer_s req_q;
	logic reg_wr_q, reg_rd_q;
	logic shift_right_q;
	logic [7:0] vector_q;
	logic [MCR_KEEP_W-1:0] master_q;
	logic chan_a_q, chan_b_q, sw_full_q, dev_reset_q;
	logic as_rise, ds_fall, ds_rise, coinc, hw_cond, rst_busy, rec_busy, blocked;
	logic go, acc_ok, acc_go, ack_go, wr_go, rec_start;
	logic [3:0] idx;
	logic chan;

	// Edge detection on synchronous strobes
	assign as_rise = !as_q && address_strobe_n;
	assign ds_fall = ds_q && !data_strobe_n;
	assign ds_rise = !ds_q && data_strobe_n;
	assign coinc = select_live && !data_strobe_n;
	assign hw_cond = !address_strobe_n && !data_strobe_n; // R19
	assign blocked = rst || rst_busy; // R20

	// Data phase start: acknowledge keys off data strobe alone
	assign go = (state_q == ST_ADDR) && (ack_q ? ds_fall : (coinc && !coinc_q)); // R8 R9
	assign acc_ok = !ack_q && sel_q && !rec_busy && !blocked; // R3 R9 R20
	assign acc_go = go && acc_ok;
	assign wr_go = acc_go && !direction; // R8
	assign ack_go = go && ack_q && int_request && chain_enable_in && !blocked; // R11
	assign idx = decode_index(addr_q);
	assign chan = decode_chan(addr_q, shift_right_q); // R14 R15
	assign rec_start = (acc_go && idx != IDX_BUFFER) || ((state_q == ST_DATA) && ds_rise && buf_q); // R3 R4

	// Reset stretcher: held through the strobe condition, then four more cycles
	mbhi_hold #(.CYCLES(RESET_STRETCH_CYC)) u_rst_hold (
		.clk(clk),
		.clr(1'b0),
		.hold_in(rst || hw_cond || sw_full_q), // R19 R20
		.start(1'b0),
		.busy(rst_busy)
	);

	// Recovery window after each access to this device
	mbhi_hold #(.CYCLES(RECOVERY_CYC)) u_rec_hold (
		.clk(clk),
		.clr(blocked),
		.hold_in(1'b0),
		.start(rec_start), // R3
		.busy(rec_busy)
	);

	// Previous strobe levels; idle high so reset does not fake an edge
	always_ff @(posedge clk) begin
		if (rst) begin
			as_q <= 1'b1;
			ds_q <= 1'b1;
			coinc_q <= 1'b0;
		end else begin
			as_q <= address_strobe_n;
			ds_q <= data_strobe_n;
			coinc_q <= coinc;
		end
	end

	// Address phase capture
	always_ff @(posedge clk) begin
		if (rst) begin
			addr_q <= 8'h00;
			ack_q <= 1'b0;
			sel_q <= 1'b0;
		end else if (as_rise) begin
			addr_q <= muxed_bus_in; // R1
			ack_q <= !ack_cycle_n; // R1
			sel_q <= !select_latched_n; // R1
		end
	end

	// Transaction sequencer
	always_ff @(posedge clk) begin
		if (blocked) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (as_rise) state_q <= ST_ADDR;
				end
				ST_ADDR: begin
					if (as_rise) state_q <= ST_ADDR;
					else if (go) state_q <= ST_DATA;
				end
				ST_DATA: begin
					if (as_rise) state_q <= ST_ADDR;
					else if (ds_rise) state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Requests toward the channel registers, one pulse each
	always_ff @(posedge clk) begin
		if (rst) begin
			req_q <= '0;
			reg_wr_q <= 1'b0;
			reg_rd_q <= 1'b0;
			buf_q <= 1'b0;
		end else begin
			reg_wr_q <= wr_go; // R8
			reg_rd_q <= acc_go && direction; // R5
			if (acc_go) begin
				req_q.chan <= chan;
				req_q.index <= direction ? read_alias(idx) : idx; // R17
				req_q.data <= muxed_bus_in; // R8
				buf_q <= (idx == IDX_BUFFER); // R4
			end else if (state_q != ST_DATA) begin
				buf_q <= 1'b0;
			end
		end
	end

	// Bus drive: read data lands on the edge the enable rises; the vector lands one cycle before it
	always_ff @(posedge clk) begin
		if (blocked) begin
			drv_q <= 1'b0;
			rd_load_q <= 1'b0;
			bus_out_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			rd_load_q <= acc_go && direction;
			if (acc_go && direction) drv_q <= 1'b1;
			else if (ack_go) drv_q <= 1'b1; // R11
			else if (ds_rise || as_rise) drv_q <= 1'b0; // R23
			if (rd_load_q) bus_out_q <= rd_data;
			else if (ack_go) bus_out_q <= int_vector; // R11
			oe_q <= drv_q && !data_strobe_n && (ack_q || select_live); // R6 R23
		end
	end

	// Interrupt side: pending update per address strobe, acknowledge answer
	always_ff @(posedge clk) begin
		if (blocked) begin
			pend_q <= 1'b0;
			ius_q <= 1'b0;
			answered_q <= 1'b0;
			irq_n_q <= 1'b1;
		end else begin
			pend_q <= as_rise; // R2
			ius_q <= ack_go; // R11
			if (ack_go) answered_q <= 1'b1;
			else if (as_rise) answered_q <= 1'b0;
			irq_n_q <= (ack_go || answered_q) ? 1'b1 : !int_request; // R12
		end
	end

	// Shared and command registers owned by the port
	always_ff @(posedge clk) begin
		chan_a_q <= 1'b0;
		chan_b_q <= 1'b0;
		sw_full_q <= 1'b0;
		if (rst || hw_cond) begin
			master_q <= MCR_RESET_VAL;
			vector_q <= VECTOR_RESET_VAL;
		end
		if (blocked) begin
			shift_right_q <= 1'b0; // R14
		end else if (wr_go) begin
			case (idx)
				IDX_COMMAND: begin
					if (chan == CHAN_B && muxed_bus_in[SHIFT_CMD_LSB +: 2] == CMD_SHIFT_LEFT) shift_right_q <= 1'b0; // R16
					if (chan == CHAN_B && muxed_bus_in[SHIFT_CMD_LSB +: 2] == CMD_SHIFT_RIGHT) shift_right_q <= 1'b1; // R16
				end
				IDX_VECTOR: vector_q <= muxed_bus_in; // R18
				IDX_MASTER: begin
					master_q <= muxed_bus_in[MCR_KEEP_W-1:0]; // R18 R22
					chan_a_q <= muxed_bus_in[MCR_CMD_LSB +: 2] == RST_CHAN_A; // R21
					chan_b_q <= muxed_bus_in[MCR_CMD_LSB +: 2] == RST_CHAN_B; // R21
					sw_full_q <= muxed_bus_in[MCR_CMD_LSB +: 2] == RST_FULL; // R21 R20
				end
				default: shift_right_q <= shift_right_q;
			endcase
		end
	end

	// Stretched reset seen by the channels
	always_ff @(posedge clk) begin
		dev_reset_q <= blocked; // R20
	end

	assign muxed_bus_out = bus_out_q;
	assign muxed_bus_oe = oe_q;
	assign irq_out_n = irq_n_q;
	assign ius_set = ius_q;
	assign pending_update = pend_q;
	assign reg_req = req_q;
	assign reg_wr = reg_wr_q;
	assign reg_rd = reg_rd_q;
	assign shift_right = shift_right_q;
	assign vector_reg = vector_q;
	assign master_control = master_q;
	assign chan_a_reset = chan_a_q;
	assign chan_b_reset = chan_b_q;
	assign dev_reset = dev_reset_q;

	// Checks guarding the bus protocol
	property p_addr_cap;
		@(posedge clk) disable iff (rst) as_rise |=> addr_q == $past(muxed_bus_in) && ack_q == !$past(ack_cycle_n);
	endproperty
	a_addr_cap: assert property (p_addr_cap) else $error("address not captured"); // R1

	property p_pend;
		@(posedge clk) disable iff (blocked) as_rise |=> pending_update;
	endproperty
	a_pend: assert property (p_pend) else $error("pending update missing"); // R2

	property p_recov;
		@(posedge clk) disable iff (blocked) acc_go && idx != IDX_BUFFER |=> rec_busy [*4];
	endproperty
	a_recov: assert property (p_recov) else $error("recovery shorter than four cycles"); // R3

	property p_oe_live;
		@(posedge clk) disable iff (rst) muxed_bus_oe && !ack_q |-> $past(select_live) && !$past(data_strobe_n);
	endproperty
	a_oe_live: assert property (p_oe_live) else $error("bus driven outside read window"); // R6

	property p_wr_cap;
		@(posedge clk) disable iff (rst) wr_go |=> reg_wr && reg_req.data == $past(muxed_bus_in);
	endproperty
	a_wr_cap: assert property (p_wr_cap) else $error("write data not captured"); // R8

	property p_ack_ignore;
		@(posedge clk) disable iff (rst) go && ack_q |=> !reg_wr && !reg_rd;
	endproperty
	a_ack_ignore: assert property (p_ack_ignore) else $error("access during acknowledge"); // R9

	property p_irq_ack;
		@(posedge clk) disable iff (blocked) ack_go |=> irq_out_n && ius_set ##1 muxed_bus_out == $past(int_vector, 2);
	endproperty
	a_irq_ack: assert property (p_irq_ack) else $error("acknowledge not answered"); // R11 R12

	property p_hw_hold;
		@(posedge clk) disable iff (rst) hw_cond ##1 !hw_cond |-> rst_busy [*4] ##1 dev_reset;
	endproperty
	a_hw_hold: assert property (p_hw_hold) else $error("reset not stretched"); // R19 R20

	property p_shift_rst;
		@(posedge clk) blocked |=> !shift_right;
	endproperty
	a_shift_rst: assert property (p_shift_rst) else $error("shift mode not left after reset"); // R14

	property p_mcr_keep;
		@(posedge clk) disable iff (rst) wr_go && idx == IDX_MASTER && !hw_cond |=> master_control == $past(muxed_bus_in[5:0]);
	endproperty
	a_mcr_keep: assert property (p_mcr_keep) else $error("master bits lost"); // R22

endmodule : mbhi_port

// ===== testbench/mbhi_proc_model.sv
// Purpose: Processor model that drives the host port strobes and selects.
// Assumes: Changes its pins only on falling clk edges.
// Notes: Address strobe keeps cycling in gaps so pending updates never starve.
`timescale 1ns/1ps
module mbhi_proc_model (
	input wire logic clk,
	output logic as_n,
	output logic ds_n,
	output logic sel_n,
	output logic live,
	output logic ack_n,
	output logic dir,
	output logic drv,
	output logic [7:0] val
);
	// Idle pins: strobes high, bus released
	initial begin
		as_n = 1'b1;
		ds_n = 1'b1;
		sel_n = 1'b0;
		live = 1'b0;
		ack_n = 1'b1;
		dir = 1'b1;
		drv = 1'b0;
		val = 8'h00;
	end

	// Address phase, data phase, then a gap with the strobe cycling
	task automatic cycle(input logic an, input logic sn, input logic rd, input logic [7:0] a,
		input logic [7:0] d, input int ds_len, input int gap);
		@(negedge clk);
		as_n = 1'b0;
		ack_n = an;
		sel_n = sn;
		drv = 1'b1;
		val = a;
		@(negedge clk);
		as_n = 1'b1;
		@(negedge clk);
		drv = !rd && an;
		val = d;
		dir = rd;
		@(negedge clk);
		ds_n = 1'b0;
		live = 1'b1;
		repeat (ds_len) @(negedge clk);
		ds_n = 1'b1;
		live = 1'b0;
		drv = 1'b0;
		ack_n = 1'b1;
		// Even count of toggles leaves the strobe high; also covers recovery
		repeat (2 * gap) begin
			@(negedge clk);
			as_n = ~as_n;
		end
	endtask : cycle

	// Both strobes low together for n cycles
	task automatic hw_reset(input int n);
		@(negedge clk);
		as_n = 1'b0;
		ds_n = 1'b0;
		repeat (n) @(negedge clk);
		as_n = 1'b1;
		ds_n = 1'b1;
	endtask : hw_reset
endmodule : mbhi_proc_model

// ===== testbench/tb_muxed_bus_host_interface.sv
// Purpose: Self-checking bench for the multiplexed bus host port.
// Assumes: Channel side answers reads with a pattern built from the request.
// Notes: Released bus shows the inverse of its last level, never a stale value.
`timescale 1ns/1ps
module tb_muxed_bus_host_interface;
	import mbhi_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic as_n, ds_n, sel_n, live, ack_n, dir, drv, oe, irq_n, ius, pend, wr, rd, sr_o, car, cbr, dres;
	logic int_req = 1'b0;
	logic chain = 1'b1;
	logic sr = 1'b0;
	logic oe_q = 1'b0;
	logic [7:0] val, bus_in, bus_out, rd_data, vec;
	logic [7:0] last_q = 8'h00;
	logic [7:0] int_vector = 8'h00;
	logic [7:0] rnd = 8'h45;
	logic [5:0] mcr;
	logic [14:0] got;
	mbhi_xfer_s req;
	int error_cnt = 0;
	int num_checks = 0;
	int ius_cnt = 0;
	int a_cnt = 0;
	int b_cnt = 0;
	int pend_cnt = 0;
	int pend_at = 0;
	logic [14:0] exp_q[$];
	logic [7:0] bus_q[$];

	// Wire level from both drivers; channel read data from the request
	assign bus_in = (oe === 1'b1) ? bus_out : (drv ? val : ~last_q);
	assign rd_data = {3'h5, req.chan, req.index};

	initial forever #5 clk = ~clk;

	mbhi_proc_model pm (.clk(clk), .as_n(as_n), .ds_n(ds_n), .sel_n(sel_n), .live(live), .ack_n(ack_n),
		.dir(dir), .drv(drv), .val(val));

	mbhi_port dut (.clk(clk), .rst(rst), .address_strobe_n(as_n), .data_strobe_n(ds_n),
		.select_latched_n(sel_n), .select_live(live), .ack_cycle_n(ack_n), .direction(dir),
		.chain_enable_in(chain), .muxed_bus_in(bus_in), .muxed_bus_out(bus_out), .muxed_bus_oe(oe),
		.irq_out_n(irq_n), .int_request(int_req), .int_vector(int_vector), .ius_set(ius),
		.pending_update(pend), .reg_req(req), .reg_wr(wr), .reg_rd(rd), .rd_data(rd_data),
		.shift_right(sr_o), .vector_reg(vec), .master_control(mcr), .chan_a_reset(car),
		.chan_b_reset(cbr), .dev_reset(dres));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	function automatic logic [7:0] adr(input logic c, input logic [3:0] i);
		adr = sr ? {3'h0, i, c} : {2'h0, c, i, 1'b0};
	endfunction : adr

	// Our own reading of the incomplete read decode
	function automatic logic [3:0] fold(input logic [3:0] i);
		fold = i;
		if (i[3:2] == 2'b01) fold = {2'b00, i[1:0]};
		if (i == 4'h9) fold = 4'hD;
		if (i == 4'hB) fold = 4'hF;
		if (i == 4'hE) fold = 4'hA;
	endfunction : fold

	task automatic chk(input string nm, input logic [14:0] e, input logic [14:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr_reg(input logic c, input logic [3:0] i, input logic [7:0] d);
		exp_q.push_back({2'b10, c, i, d});
		pm.cycle(1'b1, 1'b0, 1'b0, adr(c, i), d, 3, 3);
	endtask : wr_reg

	task automatic rd_reg(input logic c, input logic [3:0] i);
		exp_q.push_back({2'b01, c, fold(i), 8'h00});
		bus_q.push_back({3'h5, c, fold(i)});
		pm.cycle(1'b1, 1'b0, 1'b1, adr(c, i), 8'h00, 3, 3);
	endtask : rd_reg

	task automatic results;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// Monitor: oldest note against each request and each first bus drive
	always @(posedge clk) begin
		oe_q <= oe;
		last_q <= bus_in;
		if (car) a_cnt++;
		if (cbr) b_cnt++;
		if (ius) ius_cnt++;
		if (pend) pend_cnt++;
		if (ius) chk("irq", 15'h1, {14'h0, irq_n});
		if (wr || rd) begin
			got = {wr, rd, req.chan, req.index, rd ? 8'h00 : req.data};
			chk("req", exp_q.size() ? exp_q.pop_front() : 15'h0, got);
		end
		if (oe && !oe_q) chk("bus", {7'h0, bus_q.size() ? bus_q.pop_front() : ~bus_out}, {7'h0, bus_out});
	end

	// Watchdog
	initial begin
		#200000;
		error_cnt++;
		results();
	end

	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		chk("reset", 15'h0, {sr_o, vec, mcr});
		// Shared vector from either channel
		rnd = lfsr(rnd);
		wr_reg(1'b1, IDX_VECTOR, rnd);
		chk("vector", {7'h0, rnd}, {7'h0, vec});
		wr_reg(CHAN_B, IDX_VECTOR, ~rnd);
		chk("vector", {7'h0, ~rnd}, {7'h0, vec});
		for (int i = 0; i < 32; i++) rd_reg(i[4], i[3:0]);
		// Shift-right decode, then back
		wr_reg(CHAN_B, IDX_COMMAND, {6'h0, CMD_SHIFT_RIGHT});
		sr = 1'b1;
		chk("shift", 15'h1, {14'h0, sr_o});
		rnd = lfsr(rnd);
		wr_reg(1'b1, IDX_VECTOR, rnd);
		chk("vector", {7'h0, rnd}, {7'h0, vec});
		rd_reg(1'b1, 4'h9);
		wr_reg(CHAN_B, IDX_COMMAND, {6'h0, CMD_SHIFT_LEFT});
		sr = 1'b0;
		chk("shift", 15'h0, {14'h0, sr_o});
		// Master reset commands; other bits kept
		for (int c = 1; c < 4; c++) begin
			if (c == 3) wr_reg(CHAN_B, IDX_COMMAND, {6'h0, CMD_SHIFT_RIGHT});
			sr = (c == 3);
			rnd = lfsr(rnd);
			wr_reg(c[0], IDX_MASTER, {c[1:0], rnd[5:0]});
			sr = 1'b0;
			chk("master", {9'h0, rnd[5:0]}, {9'h0, mcr});
			// Pulse counts are cumulative; a full reset must not pulse either channel
			chk("resets", {11'h0, 2'(c >= RST_CHAN_A), 2'h1}, {11'h0, a_cnt[1:0], b_cnt[1:0]});
		end
		chk("shift", 15'h0, {14'h0, sr_o});
		// Latched select high: ignored
		rnd = lfsr(rnd);
		wr_reg(CHAN_B, IDX_VECTOR, rnd);
		pm.cycle(1'b1, 1'b1, 1'b0, adr(1'b0, IDX_VECTOR), ~rnd, 3, 3);
		chk("vector", {7'h0, rnd}, {7'h0, vec});
		// Buffer write counts recovery from data strobe rise, so a quick follow-up is refused
		exp_q.push_back({2'b10, CHAN_B, IDX_BUFFER, rnd});
		pm.cycle(1'b1, 1'b0, 1'b0, adr(CHAN_B, IDX_BUFFER), rnd, 3, 0);
		pm.cycle(1'b1, 1'b0, 1'b0, adr(CHAN_B, IDX_VECTOR), ~rnd, 3, 3);
		chk("vector", {7'h0, rnd}, {7'h0, vec});
		// Acknowledge cycles, answered then chain low
		@(negedge clk);
		int_req = 1'b1;
		int_vector = lfsr(rnd);
		repeat (3) @(negedge clk);
		chk("irq", 15'h0, {14'h0, irq_n});
		bus_q.push_back(int_vector);
		pend_at = pend_cnt;
		pm.cycle(1'b0, 1'b1, 1'b0, 8'hFF, 8'h00, 3, 3);
		// Let the last strobe rise reach the pending pulse
		repeat (2) @(negedge clk);
		chk("pend", 15'h4, 15'(pend_cnt - pend_at));
		chk("ius", 15'h1, ius_cnt[14:0]);
		chain = 1'b0;
		pm.cycle(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 3, 3);
		chk("ius", 15'h1, ius_cnt[14:0]);
		chain = 1'b1;
		int_req = 1'b0;
		// Hardware reset by both strobes low, then stretch
		pm.hw_reset(3);
		repeat (3) @(negedge clk);
		chk("stretch", 15'h1, {14'h0, dres});
		repeat (8) @(negedge clk);
		chk("stretch", 15'h0, {14'h0, dres});
		chk("hw reset", 15'h0, {sr_o, vec, mcr});
		chk("notes", 15'h0, 15'(exp_q.size() + bus_q.size()));
		results();
	end
endmodule : tb_muxed_bus_host_interface
